// >>> include/tmtq_pkg.sv
// How it works
// - The channel takes an external trigger from one of its two channel I/O pins.
// - A mode bit picks the first or the second channel I/O pin as external trigger input.
// - An edge field picks rising, falling or either edge of that pin as the trigger.
// - With the edge field at zero no external trigger is ever made.
// - The mask view reads one for overflow and load-overrun interrupts while enabled.
// - The mask view shows the three compare interrupt enables, one bit each.
// - The mask view shows the two capture-load interrupt enables, one bit each.
// - The index flag reads one if the index input changed since the last status read.
// - The direction-change flag reads one if direction reversed since the last status read.
// - The error flag reads one if a sequence error was seen since the last status read.
// - The direction bit always shows the live direction and is not cleared by reading.
package tmtq_pkg;
    localparam int ADR_W = 32;
    localparam int DAT_W = 32;
    localparam logic [31:0] ADR_MODE = 32'h40010004;
    localparam logic [31:0] ADR_IEN_SET = 32'h40010024;
    localparam logic [31:0] ADR_IEN_CLR = 32'h40010028;
    localparam logic [31:0] ADR_MASK_VIEW = 32'h4001002c;
    localparam logic [31:0] ADR_QSTAT = 32'h400100d4;
    localparam logic [31:0] ADR_EV_STAT = 32'h400100e0;
    localparam logic [31:0] ADR_EV_MASK = 32'h400100e4;
    // Mode register fields
    localparam int MODE_PIN_BIT = 10;
    localparam int MODE_EDGE_LSB = 8;
    localparam int EDGE_W = 2;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Mask view layout
    localparam int IEN_W = 10;
    localparam logic [9:0] IEN_RESET = 10'h000;
    // Quadrature status layout
    localparam int Q_IDX_BIT = 0;
    localparam int Q_DCHG_BIT = 1;
    localparam int Q_ERR_BIT = 2;
    localparam int Q_DIR_BIT = 8;
    // Event status layout
    localparam int EV_W = 4;
    localparam int EV_TRIG_BIT = 0;
    localparam int EV_IDX_BIT = 1;
    localparam int EV_DCHG_BIT = 2;
    localparam int EV_ERR_BIT = 3;
    localparam logic [3:0] EV_RESET = 4'h0;
    // Synchronised inputs
    localparam int IN_W = 5;
    localparam int IN_IO1 = 0;
    localparam int IN_IO2 = 1;
    localparam int IN_QA = 2;
    localparam int IN_QB = 3;
    localparam int IN_IDX = 4;
    typedef enum logic {
        TMTQ_FWD,
        TMTQ_REV
    } tmtq_dir_t;
endpackage

// >>> src/tmtq_sync_edge.sv
`timescale 1ns/1ns
module tmtq_sync_edge #(
    parameter int WIDTH = 5
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);
    if (WIDTH < 1) begin : g_bad_width
        $error("tmtq_sync_edge: WIDTH must be at least 1");
    end
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        logic meta_ff;
        logic sync_ff;
        logic prev_ff;
        logic rise_ff;
        logic fall_ff;
        // First stage feeds only the second one
        always_ff @(posedge i_mclk) begin
            if (i_rst) begin
                meta_ff <= 1'b0;
                sync_ff <= 1'b0;
                prev_ff <= 1'b0;
            end else begin
                meta_ff <= i_pin[g];
                sync_ff <= meta_ff;
                prev_ff <= sync_ff;
            end
        end
        always_ff @(posedge i_mclk) begin
            if (i_rst) begin
                rise_ff <= 1'b0;
                fall_ff <= 1'b0;
            end else begin
                rise_ff <= sync_ff & ~prev_ff;
                fall_ff <= ~sync_ff & prev_ff;
            end
        end
        assign o_level[g] = prev_ff;
        assign o_rise[g] = rise_ff;
        assign o_fall[g] = fall_ff;
    end
endmodule

// >>> src/tmtq_top.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
module tmtq_top
    import tmtq_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [DAT_W-1:0] i_wb_dat,
    output logic [DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_chan_io_first,
    input wire logic i_chan_io_second,
    input wire logic i_quad_a,
    input wire logic i_quad_b,
    input wire logic i_quad_index,
    output logic o_ext_trig,
    output logic [IEN_W-1:0] o_irq_en,
    output logic o_quad_dir,
    output logic o_irq
);
    logic ack_ff;
    logic [DAT_W-1:0] rdat_ff;
    logic [DAT_W-1:0] nxt_rdat;
    logic req;
    logic wr;
    logic rd;
    logic [DAT_W-1:0] wmask;
    logic [DAT_W-1:0] wdat;

    logic pin_sel_ff;
    logic [EDGE_W-1:0] edge_sel_ff;
    logic [IEN_W-1:0] ien_ff;
    logic trig_ff;
    logic nxt_trig;
    logic [EV_W-1:0] ev_stat_ff;
    logic [EV_W-1:0] ev_mask_ff;
    logic [EV_W-1:0] ev_in;
    logic irq_ff;

    logic [IN_W-1:0] in_lvl;
    logic [IN_W-1:0] in_rise;
    logic [IN_W-1:0] in_fall;

    logic [1:0] ab_prev_ff;
    logic [1:0] ab_now;
    logic step_fwd;
    logic step_rev;
    logic step_err;
    tmtq_dir_t dir_ff;
    tmtq_dir_t nxt_dir;
    logic dchg_ev;
    logic idx_ev;
    logic idx_flag_ff;
    logic dchg_flag_ff;
    logic err_flag_ff;
    logic qstat_rd;

    // Bus handshake: answer one cycle after the request
    assign req = i_wb_cyc & i_wb_stb & ~ack_ff;
    assign wr = req & i_wb_we;
    assign rd = req & ~i_wb_we;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{i_wb_sel[i]}};
        end
    end

    assign wdat = i_wb_dat & wmask;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    // Read data mux; unmapped reads give zero
    always_comb begin
        nxt_rdat = '0;
        if (i_wb_adr == ADR_MODE) begin
            nxt_rdat[MODE_PIN_BIT] = pin_sel_ff;
            nxt_rdat[MODE_EDGE_LSB +: EDGE_W] = edge_sel_ff;
        end else if (i_wb_adr == ADR_MASK_VIEW) begin
            nxt_rdat[IEN_W-1:0] = ien_ff;
        end else if (i_wb_adr == ADR_QSTAT) begin
            nxt_rdat[Q_IDX_BIT] = idx_flag_ff;
            nxt_rdat[Q_DCHG_BIT] = dchg_flag_ff;
            nxt_rdat[Q_ERR_BIT] = err_flag_ff;
            nxt_rdat[Q_DIR_BIT] = (dir_ff == TMTQ_REV);
        end else if (i_wb_adr == ADR_EV_STAT) begin
            nxt_rdat[EV_W-1:0] = ev_stat_ff;
        end else if (i_wb_adr == ADR_EV_MASK) begin
            nxt_rdat[EV_W-1:0] = ev_mask_ff;
        end else begin
            nxt_rdat = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdat_ff <= '0;
        end else if (rd) begin
            rdat_ff <= nxt_rdat;
        end else if (ack_ff) begin
            rdat_ff <= '0;
        end
    end

    assign o_wb_ack = ack_ff;
    assign o_wb_dat = rdat_ff;

    // Channel mode: pin select and edge select
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_sel_ff <= 1'b0;
            edge_sel_ff <= EDGE_NONE;
        end else if (wr && i_wb_adr == ADR_MODE) begin
            if (i_wb_sel[MODE_PIN_BIT/8]) begin
                pin_sel_ff <= wdat[MODE_PIN_BIT];
                edge_sel_ff <= wdat[MODE_EDGE_LSB +: EDGE_W];
            end
        end
    end

    // Interrupt enables: set and clear by writing ones
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ien_ff <= IEN_RESET;
        end else if (wr && i_wb_adr == ADR_IEN_SET) begin
            ien_ff <= ien_ff | wdat[IEN_W-1:0];
        end else if (wr && i_wb_adr == ADR_IEN_CLR) begin
            ien_ff <= ien_ff & ~wdat[IEN_W-1:0];
        end
    end

    assign o_irq_en = ien_ff;

    // All pins pass the same three-stage synchroniser
    tmtq_sync_edge #(
        .WIDTH(IN_W)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin({i_quad_index, i_quad_b, i_quad_a, i_chan_io_second, i_chan_io_first}),
        .o_level(in_lvl),
        .o_rise(in_rise),
        .o_fall(in_fall)
    );

    // External trigger edge select
    always_comb begin
        logic r;
        logic f;
        r = pin_sel_ff ? in_rise[IN_IO2] : in_rise[IN_IO1];
        f = pin_sel_ff ? in_fall[IN_IO2] : in_fall[IN_IO1];
        case (edge_sel_ff)
            EDGE_RISE: nxt_trig = r;
            EDGE_FALL: nxt_trig = f;
            EDGE_BOTH: nxt_trig = r | f;
            default: nxt_trig = 1'b0;
        endcase
    end

    // Trigger leaves as a one-cycle pulse for the counter
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            trig_ff <= 1'b0;
        end else begin
            trig_ff <= nxt_trig;
        end
    end

    assign o_ext_trig = trig_ff;

    // Quadrature decoding on synchronised phases
    assign ab_now = {in_lvl[IN_QB], in_lvl[IN_QA]};

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ab_prev_ff <= 2'h0;
        end else begin
            ab_prev_ff <= ab_now;
        end
    end

    // Gray order 00,01,11,10 counts forward
    always_comb begin
        step_fwd = 1'b0;
        step_rev = 1'b0;
        step_err = 1'b0;
        case ({ab_prev_ff, ab_now})
            4'h1, 4'h7, 4'he, 4'h8: step_fwd = 1'b1;
            4'h2, 4'hb, 4'hd, 4'h4: step_rev = 1'b1;
            4'h3, 4'hc, 4'h6, 4'h9: step_err = 1'b1;
            default: step_fwd = 1'b0;
        endcase
    end

    always_comb begin
        nxt_dir = dir_ff;
        if (step_fwd) begin
            nxt_dir = TMTQ_FWD;
        end else if (step_rev) begin
            nxt_dir = TMTQ_REV;
        end
    end

    assign dchg_ev = (nxt_dir != dir_ff);
    assign idx_ev = in_rise[IN_IDX] | in_fall[IN_IDX];

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dir_ff <= TMTQ_FWD;
        end else begin
            dir_ff <= nxt_dir;
        end
    end

    assign o_quad_dir = (dir_ff == TMTQ_REV);

    // Status read clears flags at the edge that takes the data
    assign qstat_rd = rd && (i_wb_adr == ADR_QSTAT);

    // Set beats clear so no event is lost
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            idx_flag_ff <= 1'b0;
        end else begin
            idx_flag_ff <= (idx_flag_ff & ~qstat_rd) | idx_ev;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dchg_flag_ff <= 1'b0;
        end else begin
            dchg_flag_ff <= (dchg_flag_ff & ~qstat_rd) | dchg_ev;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            err_flag_ff <= 1'b0;
        end else begin
            err_flag_ff <= (err_flag_ff & ~qstat_rd) | step_err;
        end
    end

    // Sticky event status, write one to clear
    always_comb begin
        ev_in = '0;
        ev_in[EV_TRIG_BIT] = nxt_trig;
        ev_in[EV_IDX_BIT] = idx_ev;
        ev_in[EV_DCHG_BIT] = dchg_ev;
        ev_in[EV_ERR_BIT] = step_err;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ev_stat_ff <= EV_RESET;
        end else if (wr && i_wb_adr == ADR_EV_STAT) begin
            ev_stat_ff <= (ev_stat_ff & ~wdat[EV_W-1:0]) | ev_in;
        end else begin
            ev_stat_ff <= ev_stat_ff | ev_in;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ev_mask_ff <= EV_RESET;
        end else if (wr && i_wb_adr == ADR_EV_MASK) begin
            ev_mask_ff <= wdat[EV_W-1:0];
        end
    end

    // Registered level, one cycle behind status
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(ev_stat_ff & ev_mask_ff);
        end
    end

    assign o_irq = irq_ff;
endmodule

// >>> verification/tmtq_monitor.sv
`timescale 1ns/1ns
module tmtq_monitor
    import tmtq_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [DAT_W-1:0] i_wb_dat,
    input wire logic [DAT_W-1:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_chan_io_first,
    input wire logic i_chan_io_second,
    input wire logic i_quad_a,
    input wire logic i_quad_b,
    input wire logic i_quad_index,
    input wire logic o_ext_trig,
    input wire logic [IEN_W-1:0] o_irq_en,
    input wire logic o_quad_dir,
    input wire logic o_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_ack_after_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack late");
    a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack too long");
    a_ack_needs_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("ack without request");
    a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == '0)
        else $error("read data not zero");
    a_trig_needs_edge: assert property (
        ($stable(i_chan_io_first) && $stable(i_chan_io_second)) [*6] |=> !o_ext_trig)
        else $error("trigger without pin edge");
    // Back-to-back pulses are legal only for pin edges one cycle apart
    a_trig_one_cycle: assert property (
        o_ext_trig && $past(i_chan_io_first, 3) == $past(i_chan_io_first, 4)
            && $past(i_chan_io_second, 3) == $past(i_chan_io_second, 4) |=> !o_ext_trig)
        else $error("trigger pulse too long");
    a_en_by_write: assert property (
        $changed(o_irq_en) |-> $past(i_wb_we) && (o_wb_ack || $past(o_wb_ack)))
        else $error("enable image moved without write");
    // A read must never move the live direction, only phase activity may
    a_dir_needs_phase: assert property (
        ($stable(i_quad_a) && $stable(i_quad_b)) [*6] |=> $stable(o_quad_dir))
        else $error("direction moved without phases");
    a_irq_drop_write: assert property ($fell(o_irq) |-> $past(o_wb_ack) || $past(o_wb_ack, 2))
        else $error("irq dropped without write");

    c_trig: cover property (o_ext_trig);
    c_irq: cover property ($rose(o_irq));
    c_dir: cover property ($rose(o_quad_dir));
endmodule

// >>> verification/tmtq_pin_model.sv
`timescale 1ns/1ns
module tmtq_pin_model (
    input wire logic i_mclk,
    input wire logic [2:0] i_cmd,
    output logic o_qa,
    output logic o_qb,
    output logic o_qx,
    output logic o_io1,
    output logic o_io2
);
    // Position count; phases are its gray image, so a jump of 2 flips both
    logic [1:0] pos_ff = 2'h0;
    logic [2:0] pin_ff = 3'h0;
    always @(posedge i_mclk) begin
        case (i_cmd)
            3'h1: pos_ff <= pos_ff + 2'h1;
            3'h2: pos_ff <= pos_ff - 2'h1;
            3'h3: pos_ff <= pos_ff + 2'h2;
            3'h4: pin_ff[0] <= ~pin_ff[0];
            3'h5: pin_ff[1] <= ~pin_ff[1];
            3'h6: pin_ff[2] <= ~pin_ff[2];
            default: pos_ff <= pos_ff;
        endcase
    end
    assign o_qb = pos_ff[1];
    assign o_qa = pos_ff[1] ^ pos_ff[0];
    assign o_qx = pin_ff[0];
    assign o_io1 = pin_ff[1];
    assign o_io2 = pin_ff[2];
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb
    import tmtq_pkg::*;
;
    logic i_mclk, i_rst, cyc, stb, we, ack, qa, qb, qx, io1, io2, trig, dir, irq;
    logic [31:0] adr, wd, rdat, d;
    logic [3:0] sel, bsel;
    logic [9:0] ien;
    logic [2:0] cmd;
    int fails, n_tests, trig_n, cycles;
    logic [2:0] qc [7] = '{3'h1, 3'h1, 3'h2, 3'h0, 3'h4, 3'h3, 3'h0};
    logic [31:0] qe [7] = '{32'h0, 32'h0, 32'h102, 32'h100, 32'h101, 32'h104, 32'h100};
    logic [31:0] te [4] = '{32'h0, 32'h1, 32'h1, 32'h2};

    tmtq_top DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_chan_io_first(io1), .i_chan_io_second(io2), .i_quad_a(qa), .i_quad_b(qb),
        .i_quad_index(qx), .o_ext_trig(trig), .o_irq_en(ien), .o_quad_dir(dir), .o_irq(irq));
    tmtq_pin_model PM (.i_mclk(i_mclk), .i_cmd(cmd), .o_qa(qa), .o_qb(qb), .o_qx(qx),
        .o_io1(io1), .o_io2(io2));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits on ack with no assumed latency; only the cycle ceiling ends it
    task bus(input logic w, input logic [31:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= v;
        sel <= bsel;
        @(posedge i_mclk iff ack === 1'b1);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task pin(input logic [2:0] c);
        @(posedge i_mclk);
        cmd <= c;
        @(posedge i_mclk);
        cmd <= 3'h0;
        repeat (8) @(posedge i_mclk);
    endtask

    task results();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cycles++;
        if (trig === 1'b1) trig_n++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end

    initial begin
        i_rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        wd = 32'h0;
        sel = 4'hf;
        bsel = 4'hf;
        cmd = 3'h0;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        bus(1'b0, ADR_MASK_VIEW, 32'h0);
        chk(d, 32'h0);
        for (int i = 0; i < IEN_W; i++) begin
            bus(1'b1, ADR_IEN_SET, 32'h1 << i);
            bus(1'b0, ADR_MASK_VIEW, 32'h0);
            chk(d, (32'h2 << i) - 32'h1);
        end
        bus(1'b1, ADR_IEN_CLR, 32'h55);
        bus(1'b1, ADR_MASK_VIEW, 32'h0);
        bus(1'b0, ADR_MASK_VIEW, 32'h0);
        chk(d, 32'h3aa);
        chk(32'(ien), 32'h3aa);
        bus(1'b0, 32'h40010100, 32'h0);
        chk(d, 32'h0);
        $display("test mask view done");
        for (int p = 0; p < 2; p++) begin
            for (int e = 0; e < 4; e++) begin
                bus(1'b1, ADR_MODE, 32'((p << MODE_PIN_BIT) | (e << MODE_EDGE_LSB)));
                trig_n = 0;
                pin(3'h6 - 3'(p));
                pin(3'h6 - 3'(p));
                pin(3'h5 + 3'(p));
                pin(3'h5 + 3'(p));
                chk(32'(trig_n), te[e]);
            end
        end
        bsel = 4'h1;
        bus(1'b1, ADR_MODE, 32'h0);
        bsel = 4'hf;
        bus(1'b0, ADR_MODE, 32'h0);
        chk(d, 32'h700);
        $display("test trigger done");
        for (int k = 0; k < 7; k++) begin
            pin(qc[k]);
            bus(1'b0, ADR_QSTAT, 32'h0);
            chk(d, qe[k]);
        end
        chk(32'(dir), 32'h1);
        $display("test quadrature done");
        bus(1'b1, ADR_EV_STAT, 32'hf);
        bus(1'b1, ADR_EV_MASK, 32'h2);
        pin(3'h4);
        chk(32'(irq), 32'h1);
        bus(1'b0, ADR_EV_STAT, 32'h0);
        chk(d, 32'h2);
        bus(1'b1, ADR_EV_MASK, 32'h0);
        pin(3'h0);
        chk(32'(irq), 32'h0);
        bus(1'b1, ADR_EV_MASK, 32'h2);
        pin(3'h0);
        chk(32'(irq), 32'h1);
        bus(1'b1, ADR_EV_STAT, 32'h2);
        pin(3'h0);
        chk(32'(irq), 32'h0);
        $display("test interrupt done");
        results();
    end
endmodule

bind tmtq_top tmtq_monitor MON (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .i_chan_io_first(i_chan_io_first),
    .i_chan_io_second(i_chan_io_second),
    .i_quad_a(i_quad_a),
    .i_quad_b(i_quad_b),
    .i_quad_index(i_quad_index),
    .o_ext_trig(o_ext_trig),
    .o_irq_en(o_irq_en),
    .o_quad_dir(o_quad_dir),
    .o_irq(o_irq)
);
